// file: cif_core_irq.sv
// Core-level pending flags, level mask and acknowledge selection.
// Assumes synchronous inputs in the CPU clock domain and single-word
// data-space reads and writes presented for one enabled cycle each.
`timescale 1ns/1ps

// Overview of operation
// - Pending-flag register at 0006h, bits 0-5 are levels one to six.
// - A level flag sets only from a forwarded peripheral request.
// - Writing 1 clears a pending flag; writing 0 leaves it alone.
// - Writing back the value just read clears all flags it showed.
// - A hardware acknowledge clears that level's pending flag.
// - Reset clears all six pending flags.
// - Acknowledge touches only the core flag, never peripheral flags.
// - A software-instruction acknowledge leaves the pending flag set.
// - Bits 15-6 of both registers always read as zero.
// - Mask register at 0004h, a 1 unmasks and a 0 masks a level.
// - The mask has no effect on the nonmaskable input or reset.
// - A masked level is never acknowledged by hardware; a software instruction can acknowledge it.
// - Lowest unmasked pending level is acknowledged when not globally disabled and no software instruction is requested.
// - Reset leaves the mask bits unchanged.
// - A level flag means at least one grouped peripheral is pending.
// - Taking an interrupt sets the global disable until software clears it.
module cif_core_irq
  import cif_pkg::*;
#(
  parameter int NUM_LEVELS = NUM_LEVELS_DEF
) (
  // Clock, reset and clock enable.
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clkEn,
  // Data-space register access.
  input wire logic [ADDR_W-1:0] busAddr,
  input wire logic [DATA_W-1:0] busWrData,
  input wire logic busWrEn,
  input wire logic busRdEn,
  output logic [DATA_W-1:0] busRdData,
  // Level requests from the expansion controller.
  input wire logic [NUM_LEVELS-1:0] levelReqN,
  // Nonmaskable request.
  input wire logic nmiReq,
  // Software interrupt instruction and global disable control.
  input wire logic swIrqReq,
  input wire logic [LEVEL_IDX_W-1:0] swIrqLevel,
  input wire logic globalDisableSet,
  input wire logic globalDisableClr,
  // Acknowledge towards the CPU core and the expansion controller.
  output logic ackValid,
  output logic ackSoftware,
  output logic [LEVEL_IDX_W-1:0] ackLevel,
  output logic nmiAck,
  output logic globalIrqDisable
);

  if (NUM_LEVELS < 1 || NUM_LEVELS > DATA_W ||
      NUM_LEVELS > (1 << LEVEL_IDX_W)) begin : g_bad
    $error("NUM_LEVELS out of range");
  end

  logic [NUM_LEVELS-1:0] pending_r;
  logic [NUM_LEVELS-1:0] levelMask_r;
  logic [DATA_W-1:0] rdData_r;
  logic ackValid_r;
  logic ackSoftware_r;
  logic [LEVEL_IDX_W-1:0] ackLevel_r;
  logic nmiAck_r;
  logic globalIrqDisable_r;
  logic [NUM_LEVELS-1:0] reqHit;
  logic [NUM_LEVELS-1:0] wrClr;
  logic [NUM_LEVELS-1:0] hwAckClr;
  logic [NUM_LEVELS-1:0] candidate;
  logic [LEVEL_IDX_W-1:0] hwLevel;
  logic hwTake;
  logic wrFlags;
  logic wrMask;

  function automatic logic [LEVEL_IDX_W-1:0] lowestSet(
    input logic [NUM_LEVELS-1:0] vec
  );
    logic [LEVEL_IDX_W-1:0] idx;
    idx = '0;
    for (int i = NUM_LEVELS - 1; i >= 0; i--) begin
      if (vec[i]) begin
        idx = LEVEL_IDX_W'(i);
      end
    end
    return idx;
  endfunction

  assign wrFlags = busWrEn && (busAddr == LEVEL_PENDING_FLAGS_ADDR);
  assign wrMask = busWrEn && (busAddr == LEVEL_MASK_ADDR);
  assign reqHit = ~levelReqN;
  assign wrClr = wrFlags ?
    busWrData[LEVEL_FIELD_LSB +: NUM_LEVELS] : '0;
  assign candidate = pending_r & levelMask_r;
  assign hwTake = (|candidate) && !globalIrqDisable_r && !swIrqReq;
  assign hwLevel = lowestSet(candidate);

  // Pending flags, one per level; a request wins over any clear.
  for (genvar g = 0; g < NUM_LEVELS; g++) begin : g_flag
    assign hwAckClr[g] = hwTake && (hwLevel == LEVEL_IDX_W'(g));
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        pending_r[g] <= PENDING_RESET[LEVEL_FIELD_LSB + g];
      end else if (clkEn) begin
        if (reqHit[g]) begin
          pending_r[g] <= 1'b1;
        end else if (wrClr[g] || hwAckClr[g]) begin
          pending_r[g] <= 1'b0;
        end
      end
    end
  end

  // Level mask has no reset term.
  always_ff @(posedge clk) begin
    if (clkEn && wrMask) begin
      levelMask_r <= busWrData[LEVEL_FIELD_LSB +: NUM_LEVELS];
    end
  end

  // Register read port.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData_r <= READ_IDLE;
    end else if (clkEn) begin
      rdData_r <= READ_IDLE;
      if (busRdEn && busAddr == LEVEL_PENDING_FLAGS_ADDR) begin
        rdData_r[LEVEL_FIELD_LSB +: NUM_LEVELS] <= pending_r;
      end else if (busRdEn && busAddr == LEVEL_MASK_ADDR) begin
        rdData_r[LEVEL_FIELD_LSB +: NUM_LEVELS] <= levelMask_r;
      end
    end
  end

  // Acknowledge selection; software instruction first.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ackValid_r <= 1'b0;
      ackSoftware_r <= 1'b0;
      ackLevel_r <= '0;
    end else if (clkEn) begin
      ackValid_r <= swIrqReq || hwTake;
      ackSoftware_r <= swIrqReq;
      if (swIrqReq) begin
        ackLevel_r <= swIrqLevel;
      end else if (hwTake) begin
        ackLevel_r <= hwLevel;
      end
    end
  end

  // Nonmaskable path bypasses the mask and the global disable.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nmiAck_r <= 1'b0;
    end else if (clkEn) begin
      nmiAck_r <= nmiReq;
    end
  end

  // Global disable is set by any taken interrupt.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      globalIrqDisable_r <= GLOBAL_DISABLE_RESET;
    end else if (clkEn) begin
      if (hwTake || swIrqReq || nmiReq || globalDisableSet) begin
        globalIrqDisable_r <= 1'b1;
      end else if (globalDisableClr) begin
        globalIrqDisable_r <= 1'b0;
      end
    end
  end

  assign busRdData = rdData_r;
  assign ackValid = ackValid_r;
  assign ackSoftware = ackSoftware_r;
  assign ackLevel = ackLevel_r;
  assign nmiAck = nmiAck_r;
  assign globalIrqDisable = globalIrqDisable_r;

  // Helper state that only the checks read.
  logic [NUM_LEVELS-1:0] prevMask_r;
  logic [NUM_LEVELS-1:0] prevReq_r;
  logic [NUM_LEVELS-1:0] prevPending_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prevMask_r <= '0;
      prevReq_r <= '0;
      prevPending_r <= '0;
    end else if (clkEn) begin
      prevMask_r <= levelMask_r;
      prevReq_r <= reqHit;
      prevPending_r <= pending_r;
    end
  end

  sequence s_hwTaken;
    ackValid_r && !ackSoftware_r;
  endsequence

  sequence s_disableHeld;
    globalIrqDisable_r [*2];
  endsequence

  property p_reqSets;
    @(posedge clk) disable iff (!rst_n)
    (clkEn && (|reqHit)) |=> ((pending_r & prevReq_r) == prevReq_r);
  endproperty
  a_reqSets: assert property (p_reqSets)
    else $error("request did not set its pending flag");

  property p_w1cClears;
    @(posedge clk) disable iff (!rst_n)
    (clkEn && wrFlags && !(|reqHit)) |=>
      ((pending_r & $past(wrClr)) == '0);
  endproperty
  a_w1cClears: assert property (p_w1cClears)
    else $error("write of one left a flag set");

  property p_zeroKeeps;
    @(posedge clk) disable iff (!rst_n)
    (clkEn && !(|reqHit) && !hwTake && !(wrFlags && |wrClr)) |=>
      (pending_r == prevPending_r);
  endproperty
  a_zeroKeeps: assert property (p_zeroKeeps)
    else $error("pending flags changed without cause");

  property p_hwAckClears;
    @(posedge clk) disable iff (!rst_n)
    (clkEn && ackValid_r && !ackSoftware_r && !prevReq_r[ackLevel_r]) |->
      !pending_r[ackLevel_r];
  endproperty
  a_hwAckClears: assert property (p_hwAckClears)
    else $error("acknowledged level still pending");

  property p_swAckKeeps;
    @(posedge clk) disable iff (!rst_n)
    (clkEn && swIrqReq && pending_r[swIrqLevel] && !wrClr[swIrqLevel]) |=>
      (ackSoftware_r && pending_r[ackLevel_r]);
  endproperty
  a_swAckKeeps: assert property (p_swAckKeeps)
    else $error("software acknowledge cleared a flag");

  property p_readZeros;
    @(posedge clk) disable iff (!rst_n)
    rdData_r[DATA_W-1:NUM_LEVELS] == '0;
  endproperty
  a_readZeros: assert property (p_readZeros)
    else $error("reserved read bits not zero");

  property p_maskedNever;
    @(posedge clk) disable iff (!rst_n)
    s_hwTaken |-> prevMask_r[ackLevel_r];
  endproperty
  a_maskedNever: assert property (p_maskedNever)
    else $error("masked level acknowledged");

  property p_unmaskedTaken;
    @(posedge clk) disable iff (!rst_n)
    (clkEn && (|candidate) && !globalIrqDisable_r && !swIrqReq) |=>
      (ackValid_r && !ackSoftware_r && ackLevel_r == $past(hwLevel));
  endproperty
  a_unmaskedTaken: assert property (p_unmaskedTaken)
    else $error("unmasked pending level not acknowledged");

  property p_takeDisables;
    @(posedge clk) disable iff (!rst_n)
    (s_hwTaken ##0 (!clkEn || !globalDisableClr)) |-> s_disableHeld;
  endproperty
  a_takeDisables: assert property (p_takeDisables)
    else $error("global disable not held after acknowledge");

  property p_nmiUnmasked;
    @(posedge clk) disable iff (!rst_n)
    (clkEn && nmiReq) |=> nmiAck_r;
  endproperty
  a_nmiUnmasked: assert property (p_nmiUnmasked)
    else $error("nonmaskable request not acknowledged");

  property p_hwAckPulse;
    @(posedge clk) disable iff (!rst_n)
    (s_hwTaken ##0 clkEn) |=> (!ackValid_r || ackSoftware_r);
  endproperty
  a_hwAckPulse: assert property (p_hwAckPulse)
    else $error("second hardware acknowledge without re-enable");

  property p_swAckNext;
    @(posedge clk) disable iff (!rst_n)
    (clkEn && swIrqReq) |=>
      (ackValid_r && ackSoftware_r && ackLevel_r == $past(swIrqLevel));
  endproperty
  a_swAckNext: assert property (p_swAckNext)
    else $error("software request not acknowledged");

  property p_maskRead;
    @(posedge clk) disable iff (!rst_n)
    (clkEn && busRdEn && busAddr == LEVEL_MASK_ADDR) |=>
      (rdData_r[LEVEL_FIELD_LSB +: NUM_LEVELS] == $past(levelMask_r));
  endproperty
  a_maskRead: assert property (p_maskRead)
    else $error("mask read data wrong");

endmodule

// file: cif_exp_model.sv
// Partner model of the expansion controller that sends level requests.
// Assumes it shares the clock and reset of the core flag logic.
`timescale 1ns/1ps
module cif_exp_model
  import cif_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Peripheral flag and enable for each level.
  input wire logic [NUM_LEVELS_DEF-1:0] periphFlag,
  input wire logic [NUM_LEVELS_DEF-1:0] periphEn,
  // Requests to the core, active low.
  output logic [NUM_LEVELS_DEF-1:0] levelReqN
);
  logic [1:0] cnt_r [NUM_LEVELS_DEF];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_LEVELS_DEF; i++) begin
        cnt_r[i] <= 2'h0;
      end
    end else begin
      for (int i = 0; i < NUM_LEVELS_DEF; i++) begin
        if (periphFlag[i] && periphEn[i] && cnt_r[i] == 2'h0) begin
          cnt_r[i] <= 2'(REQ_PULSE_CYCLES);
        end else if (cnt_r[i] != 2'h0) begin
          cnt_r[i] <= cnt_r[i] - 2'h1;
        end
      end
    end
  end
  always_comb begin
    for (int i = 0; i < NUM_LEVELS_DEF; i++) begin
      levelReqN[i] = (cnt_r[i] == 2'h0);
    end
  end
endmodule

// file: cif_pkg.sv
// Constants for the core-level interrupt flag and mask logic.
// Assumes a 16-bit data-space access port in the CPU clock domain.
package cif_pkg;
  // Data-space word width and register offsets.
  localparam int DATA_W = 16;
  localparam int ADDR_W = 16;
  localparam logic [ADDR_W-1:0] LEVEL_MASK_ADDR = 16'h0004;
  localparam logic [ADDR_W-1:0] LEVEL_PENDING_FLAGS_ADDR = 16'h0006;
  // Number of maskable levels and the position of the first level flag.
  localparam int NUM_LEVELS_DEF = 6;
  localparam int LEVEL_FIELD_LSB = 0;
  // Reset values.
  localparam logic [DATA_W-1:0] PENDING_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] READ_IDLE = 16'h0000;
  localparam logic GLOBAL_DISABLE_RESET = 1'b1;
  // Width of the level index carried with an acknowledge.
  localparam int LEVEL_IDX_W = 3;
  // Length of a level request pulse from the expansion controller.
  localparam int REQ_PULSE_CYCLES = 2;
endpackage

// file: cif_tb.sv
// Self-checking bench for the core flag and mask logic.
// Assumes the partner model drives the level requests.
`timescale 1ns/1ps
module testbench;
  import cif_pkg::*;
  localparam logic [15:0] PEND_A = LEVEL_PENDING_FLAGS_ADDR;
  localparam logic [15:0] MASK_A = LEVEL_MASK_ADDR;
  logic clk = 1'b0, rst_n = 1'b0, busWrEn = 1'b0, busRdEn = 1'b0;
  logic nmiReq = 1'b0, swIrqReq = 1'b0, globalDisableSet = 1'b0;
  logic globalDisableClr = 1'b0, ackValid, ackSoftware, nmiAck;
  logic globalIrqDisable, rdTaken = 1'b0, clkEn = 1'b1;
  logic [ADDR_W-1:0] busAddr = 16'h0000;
  logic [DATA_W-1:0] busWrData = 16'h0000, busRdData;
  logic [LEVEL_IDX_W-1:0] swIrqLevel = 3'h0, ackLevel;
  logic [5:0] levelReqN, pFlag = 6'h00, pEn = 6'h00, p;
  logic [15:0] rdQ[$], ackQ[$];
  int fail_count = 0, total_checks = 0, cycles = 0;
  int unsigned seed;
  always #4 clk = ~clk;
  cif_core_irq u_cif_core_irq (.clk, .rst_n, .clkEn, .busAddr,
    .busWrData, .busWrEn, .busRdEn, .busRdData, .levelReqN, .nmiReq,
    .swIrqReq, .swIrqLevel, .globalDisableSet, .globalDisableClr,
    .ackValid, .ackSoftware, .ackLevel, .nmiAck, .globalIrqDisable);
  cif_exp_model u_cif_exp_model (.clk, .rst_n, .periphFlag(pFlag),
    .periphEn(pEn), .levelReqN);
  task automatic chk(input string n, input logic [15:0] g, e);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // A read notes its expected word; a write sends it.
  task automatic acc(input logic w, input logic [15:0] a, d);
    @(posedge clk);
    busAddr <= a;
    busWrData <= d;
    busWrEn <= w;
    busRdEn <= !w;
    if (!w) rdQ.push_back(d);
    @(posedge clk);
    busWrEn <= 1'b0;
    busRdEn <= 1'b0;
  endtask
  task automatic fire(input logic [5:0] f, en);
    @(posedge clk);
    pFlag <= f;
    pEn <= en;
    @(posedge clk);
    pFlag <= 6'h00;
    repeat (4) @(posedge clk);
  endtask
  task automatic gd(input logic s, c, e);
    @(posedge clk);
    globalDisableSet <= s;
    globalDisableClr <= c;
    @(posedge clk);
    globalDisableSet <= 1'b0;
    globalDisableClr <= 1'b0;
    @(negedge clk);
    chk("global disable", 16'(globalIrqDisable), 16'(e));
  endtask
  always @(posedge clk) begin
    rdTaken <= busRdEn;
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count++;
      close_out();
    end
  end
  // Results are taken off the queues as they appear.
  always @(negedge clk) begin
    if (rdTaken) chk("read data", busRdData, rdQ.pop_front());
    if (ackValid !== 1'b0 || nmiAck !== 1'b0) begin
      chk("ack", {10'h000, nmiAck, ackValid,
        ackValid & ackSoftware, ackValid ? ackLevel : 3'h0},
        ackQ.size() ? ackQ.pop_front() : 16'hffff);
    end
  end
  initial begin
    seed = $urandom(32'h0000_2dad);
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    acc(0, PEND_A, 16'h0000);
    acc(1, MASK_A, 16'hffff);
    acc(0, MASK_A, 16'h003f);
    acc(0, 16'h0008, 16'h0000);
    acc(1, MASK_A, 16'h0000);
    acc(0, MASK_A, 16'h0000);
    gd(1'b1, 1'b1, 1'b1);
    gd(1'b0, 1'b1, 1'b0);
    fire(6'h3f, 6'h00);
    acc(0, PEND_A, 16'h0000);
    fire(6'h3f, 6'h3f);
    acc(0, PEND_A, 16'h003f);
    acc(1, PEND_A, 16'hffc0);
    acc(0, PEND_A, 16'h003f);
    acc(1, PEND_A, 16'h003f);
    acc(0, PEND_A, 16'h0000);
    for (int k = 0; k < 6; k++) begin
      p = 6'($urandom()) | (6'h01 << k);
      fire(p, 6'h3f);
      acc(0, PEND_A, {10'h000, p});
      ackQ.push_back(16'h0010 + 16'($clog2(p & -p)));
      acc(1, MASK_A, 16'h003f);
      repeat (3) @(posedge clk);
      chk("disable after take", 16'(globalIrqDisable), 16'h0001);
      acc(0, PEND_A, {10'h000, p & (p - 6'h01)});
      acc(1, PEND_A, 16'h003f);
      acc(1, MASK_A, 16'h0000);
      gd(1'b0, 1'b1, 1'b0);
    end
    for (int k = 0; k < 6; k++) begin
      fire(6'h01 << k, 6'h3f);
      ackQ.push_back(16'h0018 + 16'(k));
      @(posedge clk);
      swIrqReq <= 1'b1;
      swIrqLevel <= 3'(k);
      @(posedge clk);
      swIrqReq <= 1'b0;
      acc(0, PEND_A, 16'(6'h01 << k));
      acc(1, PEND_A, 16'h003f);
    end
    ackQ.push_back(16'h0020);
    @(posedge clk);
    nmiReq <= 1'b1;
    @(posedge clk);
    nmiReq <= 1'b0;
    busAddr <= PEND_A;
    busWrData <= 16'h0001;
    busWrEn <= 1'b1;
    pFlag <= 6'h01;
    @(posedge clk);
    pFlag <= 6'h00;
    repeat (2) @(posedge clk);
    busWrEn <= 1'b0;
    acc(0, PEND_A, 16'h0001);
    @(posedge clk);
    clkEn <= 1'b0;
    acc(1, PEND_A, 16'h003f);
    clkEn <= 1'b1;
    acc(0, PEND_A, 16'h0001);
    acc(1, MASK_A, 16'h0015);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    acc(0, MASK_A, 16'h0015);
    acc(0, PEND_A, 16'h0000);
    repeat (2) @(posedge clk);
    chk("pending acks", 16'(ackQ.size()), 16'h0000);
    close_out();
  end
endmodule
